// *** verilog/sleep_pkg.sv ***
// Purpose: shared constants and types of the sleep and power controller
// Assumes: AXI4-Lite register bus with 32-bit data, byte addresses
// Notes: register byte address is four times its index
package sleep_pkg;

   // ==========================================================
   // register indices and byte addresses
   localparam logic [11:0] IDX_SLEEP_CTRL = 12'h033;
   localparam logic [11:0] IDX_PWR_RED = 12'h064;
   localparam logic [11:0] IDX_DIN_DIS0 = 12'h020;
   localparam logic [11:0] IDX_DIN_DIS1 = 12'h021;
   localparam logic [11:0] IDX_CONFIG = 12'h022;
   localparam logic [11:0] IDX_STATUS = 12'h023;
   localparam logic [11:0] ADDR_SLEEP_CTRL = IDX_SLEEP_CTRL << 2;
   localparam logic [11:0] ADDR_PWR_RED = IDX_PWR_RED << 2;
   localparam logic [11:0] ADDR_DIN_DIS0 = IDX_DIN_DIS0 << 2;
   localparam logic [11:0] ADDR_DIN_DIS1 = IDX_DIN_DIS1 << 2;
   localparam logic [11:0] ADDR_CONFIG = IDX_CONFIG << 2;
   localparam logic [11:0] ADDR_STATUS = IDX_STATUS << 2;

   // ==========================================================
   // fields and reset values
   localparam int SMC_SE_BIT = 0;
   localparam int SMC_MODE_LSB = 1;
   localparam logic [7:0] SMC_RESET = 8'h00;
   localparam logic [7:0] PRR_RESET = 8'h00;
   localparam logic [7:0] PRR_WMASK = 8'hEF;
   localparam int PR_TIM2 = 6;
   localparam int PR_ADC = 0;
   localparam logic [7:0] DIN_DIS_RESET = 8'h00;
   localparam logic [11:0] CFG_RESET = 12'h000;
   localparam int CFG_T2_EN = 0;
   localparam int CFG_T2_ASYNC = 1;
   localparam int CFG_CRYSTAL = 2;
   localparam int CFG_ADC_EN = 3;
   localparam int CFG_ACMP_EN = 4;
   localparam int CFG_ACMP_REF = 5;
   localparam int CFG_BOD_FUSE = 6;
   localparam int CFG_WDT_EN = 7;
   localparam int CFG_DBG_FUSE = 8;
   localparam int CFG_T2_OVF_IE = 9;
   localparam int CFG_T2_CMP_IE = 10;
   localparam int CFG_GIE = 11;

   // ==========================================================
   // timing in cycles of aclk
   localparam logic [7:0] WAKE_HALT_CYCLES = 8'h04;
   localparam logic [7:0] STANDBY_WAKE_CYCLES = 8'h06;
   localparam logic [7:0] OSC_STARTUP_CYCLES = 8'h10;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_IDLE = 3'h0,
      MODE_NOISE = 3'h1,
      MODE_PWR_DOWN = 3'h2,
      MODE_PWR_SAVE = 3'h3,
      MODE_RSVD4 = 3'h4,
      MODE_RSVD5 = 3'h5,
      MODE_STANDBY = 3'h6,
      MODE_EXT_STANDBY = 3'h7
   } mode_t;

   typedef enum logic [1:0] {
      ST_ACTIVE = 2'h0,
      ST_ASLEEP = 2'h1,
      ST_STARTUP = 2'h3,
      ST_HALT = 2'h2
   } state_t;

endpackage

// *** verilog/sleep_ctrl.sv ***
// Purpose: sleep mode controller with clock domain gating and
//          per-peripheral clock shutdown, AXI4-Lite registers
// Assumes: sleep_exec pulses once per executed sleep instruction
// Notes: all outputs are registered, decoded from next state so they change in step with state
`timescale 1ns/10ps

// Overview of operation
// - mode 011 enters power-save on sleep
// - power-save wakes on enabled timer2 events
// - stop unused timer2 oscillator or main clock
// - sync clock in power-save feeds timer2 only
// - mode 110 with crystal enters standby
// - standby wake takes six cycles
// - mode 111 extended standby, six-cycle wake with crystal
// - reduction bit stops clock and register access; timer2 clock stays on when asynchronous
// - clearing reduction bit restarts frozen peripheral
// - module shutdown matters awake or idle, for adc also in noise, for sync timer2 also in power-save and extended standby
// - converter stays enabled; re-enable means extended
// - comparator auto-off in deep sleep modes
// - reference on while detector, comparator, converter need
// - fused brown-out detector runs in all modes
// - enabled watchdog keeps running while asleep
// - input buffers off when io, adc clocks stop
// - input disable registers switch off pin buffers
// - debug fuse keeps main clock during sleep
// - control bits 7:4 read zero, reset zero
// - decode three-bit sleep mode select
// - sleep only when sleep enable set
// - four halt cycles after start-up, then resume
// - power-down stops oscillator and generated clocks
module sleep_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_exec,
   input wire logic ext_wake,
   input wire logic int_irq,
   input wire logic adc_irq,
   input wire logic t2_ovf,
   input wire logic t2_cmp,
   input wire logic adc_conv_start,
   output logic cpu_halted,
   output logic irq_go,
   output logic cpu_clk_en,
   output logic flash_clk_en,
   output logic io_clk_en,
   output logic adc_clk_en,
   output logic async_osc_en,
   output logic main_osc_en,
   output logic t2_sync_clk_en,
   output logic [7:0] periph_clk_en,
   output logic [7:0] periph_reg_en,
   output logic adc_en,
   output logic adc_ext_conv,
   output logic acmp_en,
   output logic vref_en,
   output logic bod_en,
   output logic wdt_en,
   output logic input_buf_en,
   output logic [7:0] din_dis0,
   output logic [7:0] din_dis1
);

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_ok;
      logic w_ok;
      logic [11:0] awaddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic sleep_en;
      logic [2:0] mode_sel;
      logic [7:0] power_reduction_register;
      logic [7:0] did0;
      logic [7:0] did1;
      logic [11:0] cfg;
      sleep_pkg::state_t st;
      sleep_pkg::mode_t cur_mode;
      logic osc_keep;
      logic [7:0] cnt;
      logic adc_ext;
      logic irq_go;
      logic cpu_en;
      logic flash_en;
      logic io_en;
      logic adc_dom;
      logic async_en;
      logic osc_en;
      logic t2s_en;
      logic [7:0] per_en;
      logic acmp_on;
      logic buf_en;
      logic halted;
      logic [7:0] reg_en;
      logic vref;
   } state_all_t;

   state_all_t q_r;
   state_all_t q_nxt;

   // ==========================================================
   // register read decode
   function automatic logic [32:0] reg_read(input logic [11:0] a,
                                            input state_all_t q);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      unique case (a)
         sleep_pkg::ADDR_SLEEP_CTRL:
            r = {1'b1, 28'h0, q.mode_sel, q.sleep_en};
         sleep_pkg::ADDR_PWR_RED: r = {1'b1, 24'h0, q.power_reduction_register};
         sleep_pkg::ADDR_DIN_DIS0: r = {1'b1, 24'h0, q.did0};
         sleep_pkg::ADDR_DIN_DIS1: r = {1'b1, 24'h0, q.did1};
         sleep_pkg::ADDR_CONFIG: r = {1'b1, 20'h0, q.cfg};
         sleep_pkg::ADDR_STATUS:
            r = {1'b1, 26'h0, q.adc_ext, q.cur_mode, q.st};
         default: r = {1'b0, 32'h0000_0000};
      endcase
      return r;
   endfunction

   logic t2_wake;
   logic wake;
   logic t2_async;
   logic t2_on;
   logic [32:0] rd;
   logic deep;

   always_comb begin
      q_nxt = q_r;
      rd = reg_read(s_axi_araddr, q_r);
      t2_on = q_r.cfg[sleep_pkg::CFG_T2_EN];
      t2_async = q_r.cfg[sleep_pkg::CFG_T2_ASYNC];
      // timer2 events wake only with their mask and global enable
      t2_wake = t2_on & q_r.cfg[sleep_pkg::CFG_GIE] &
                ((t2_ovf & q_r.cfg[sleep_pkg::CFG_T2_OVF_IE]) |
                 (t2_cmp & q_r.cfg[sleep_pkg::CFG_T2_CMP_IE]));
      unique case (q_r.cur_mode)
         sleep_pkg::MODE_IDLE:
            wake = ext_wake | int_irq | adc_irq | t2_wake;
         sleep_pkg::MODE_NOISE:
            wake = ext_wake | adc_irq | (t2_wake & t2_async);
         sleep_pkg::MODE_PWR_SAVE, sleep_pkg::MODE_EXT_STANDBY:
            wake = ext_wake | t2_wake;
         default: wake = ext_wake;
      endcase
      q_nxt.irq_go = 1'b0;

      // ========================================================
      // AXI4-Lite write: address and data in either order
      if (s_axi_awvalid && q_r.awready) begin
         q_nxt.aw_ok = 1'b1;
         q_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q_r.wready) begin
         q_nxt.w_ok = 1'b1;
         q_nxt.wdata = s_axi_wdata[15:0];
         q_nxt.wstrb = s_axi_wstrb[1:0];
      end
      if (q_r.bvalid && s_axi_bready) begin
         q_nxt.bvalid = 1'b0;
      end
      if (q_r.aw_ok && q_r.w_ok && !q_r.bvalid) begin
         q_nxt.aw_ok = 1'b0;
         q_nxt.w_ok = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp = sleep_pkg::RESP_OKAY;
         unique case (q_r.awaddr)
            sleep_pkg::ADDR_SLEEP_CTRL: begin
               if (q_r.wstrb[0]) begin
                  q_nxt.sleep_en = q_r.wdata[sleep_pkg::SMC_SE_BIT];
                  q_nxt.mode_sel =
                     q_r.wdata[sleep_pkg::SMC_MODE_LSB +: 3];
               end
            end
            sleep_pkg::ADDR_PWR_RED: begin
               if (q_r.wstrb[0]) begin
                  // clock stops, peripheral state frozen outside
                  q_nxt.power_reduction_register = q_r.wdata[7:0] &
                              sleep_pkg::PRR_WMASK;
               end
            end
            sleep_pkg::ADDR_DIN_DIS0: begin
               if (q_r.wstrb[0]) begin
                  q_nxt.did0 = q_r.wdata[7:0];
               end
            end
            sleep_pkg::ADDR_DIN_DIS1: begin
               if (q_r.wstrb[0]) begin
                  q_nxt.did1 = q_r.wdata[7:0];
               end
            end
            sleep_pkg::ADDR_CONFIG: begin
               if (q_r.wstrb[0]) begin
                  q_nxt.cfg[7:0] = q_r.wdata[7:0];
               end
               if (q_r.wstrb[1]) begin
                  q_nxt.cfg[11:8] = q_r.wdata[11:8];
               end
            end
            sleep_pkg::ADDR_STATUS: ;
            default: q_nxt.bresp = sleep_pkg::RESP_SLVERR;
         endcase
      end

      // ========================================================
      // AXI4-Lite read, one outstanding
      if (q_r.rvalid && s_axi_rready) begin
         q_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q_r.arready) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rdata = rd[31:0];
         q_nxt.rresp = rd[32] ? sleep_pkg::RESP_OKAY :
                                sleep_pkg::RESP_SLVERR;
      end

      // a converter switched off marks the next conversion extended;
      // the set wins over a conversion start in the same cycle
      if (q_r.cfg[sleep_pkg::CFG_ADC_EN] &&
          !q_nxt.cfg[sleep_pkg::CFG_ADC_EN]) begin
         q_nxt.adc_ext = 1'b1;
      end else if (adc_conv_start) begin
         q_nxt.adc_ext = 1'b0;
      end

      // ========================================================
      // sleep sequencer
      unique case (q_r.st)
         sleep_pkg::ST_ACTIVE: begin
            // reserved codes never put the device to sleep
            if (sleep_exec && q_r.sleep_en &&
                q_r.mode_sel != sleep_pkg::MODE_RSVD4 &&
                q_r.mode_sel != sleep_pkg::MODE_RSVD5) begin
               q_nxt.st = sleep_pkg::ST_ASLEEP;
               q_nxt.cur_mode = sleep_pkg::mode_t'(q_r.mode_sel);
               // without a crystal standby falls back to power-down
               q_nxt.osc_keep =
                  q_r.cfg[sleep_pkg::CFG_CRYSTAL];
            end
         end
         sleep_pkg::ST_ASLEEP: begin
            if (wake) begin
               if (q_r.cur_mode == sleep_pkg::MODE_IDLE ||
                   q_r.cur_mode == sleep_pkg::MODE_NOISE) begin
                  q_nxt.st = sleep_pkg::ST_HALT;
                  q_nxt.cnt = sleep_pkg::WAKE_HALT_CYCLES - 8'h01;
               end else begin
                  q_nxt.st = sleep_pkg::ST_STARTUP;
                  if (q_r.osc_keep &&
                      (q_r.cur_mode == sleep_pkg::MODE_STANDBY ||
                       q_r.cur_mode == sleep_pkg::MODE_EXT_STANDBY))
                  begin
                     q_nxt.cnt = sleep_pkg::STANDBY_WAKE_CYCLES -
                                 8'h01;
                  end else begin
                     q_nxt.cnt = sleep_pkg::OSC_STARTUP_CYCLES - 8'h01;
                  end
               end
            end
         end
         sleep_pkg::ST_STARTUP: begin
            q_nxt.cnt = q_r.cnt - 8'h01;
            if (q_r.cnt == 8'h00) begin
               q_nxt.st = sleep_pkg::ST_HALT;
               q_nxt.cnt = sleep_pkg::WAKE_HALT_CYCLES - 8'h01;
            end
         end
         sleep_pkg::ST_HALT: begin
            q_nxt.cnt = q_r.cnt - 8'h01;
            if (q_r.cnt == 8'h00) begin
               q_nxt.st = sleep_pkg::ST_ACTIVE;
               q_nxt.irq_go = 1'b1;
            end
         end
      endcase

      if (!aresetn) begin
         q_nxt = '0;
         q_nxt.mode_sel = sleep_pkg::SMC_RESET[3:1];
         q_nxt.sleep_en = sleep_pkg::SMC_RESET[0];
         q_nxt.power_reduction_register = sleep_pkg::PRR_RESET;
         q_nxt.did0 = sleep_pkg::DIN_DIS_RESET;
         q_nxt.did1 = sleep_pkg::DIN_DIS_RESET;
         q_nxt.cfg = sleep_pkg::CFG_RESET;
         q_nxt.st = sleep_pkg::ST_ACTIVE;
         q_nxt.cur_mode = sleep_pkg::MODE_IDLE;
      end
      q_nxt.awready = !q_nxt.aw_ok && !q_nxt.bvalid;
      q_nxt.wready = !q_nxt.w_ok && !q_nxt.bvalid;
      q_nxt.arready = !q_nxt.rvalid;

      // ========================================================
      // clock domain gates from the next state
      q_nxt.cpu_en = q_nxt.st == sleep_pkg::ST_ACTIVE;
      q_nxt.flash_en = q_nxt.cpu_en;
      q_nxt.io_en = 1'b1;
      q_nxt.adc_dom = 1'b1;
      q_nxt.async_en = q_nxt.cfg[sleep_pkg::CFG_T2_ASYNC];
      q_nxt.osc_en = 1'b1;
      q_nxt.t2s_en = 1'b0;
      deep = 1'b0;
      if (q_nxt.st == sleep_pkg::ST_ASLEEP ||
          q_nxt.st == sleep_pkg::ST_STARTUP) begin
         unique case (q_nxt.cur_mode)
            sleep_pkg::MODE_IDLE: ;
            sleep_pkg::MODE_NOISE: q_nxt.io_en = 1'b0;
            sleep_pkg::MODE_PWR_SAVE, sleep_pkg::MODE_EXT_STANDBY: begin
               deep = 1'b1;
               q_nxt.io_en = 1'b0;
               q_nxt.adc_dom = 1'b0;
               q_nxt.async_en = t2_on & t2_async;
               q_nxt.t2s_en = t2_on & ~t2_async;
               q_nxt.osc_en = q_nxt.t2s_en |
                  (q_nxt.osc_keep && q_nxt.cur_mode ==
                   sleep_pkg::MODE_EXT_STANDBY);
            end
            default: begin
               deep = 1'b1;
               q_nxt.io_en = 1'b0;
               q_nxt.adc_dom = 1'b0;
               q_nxt.async_en = 1'b0;
               q_nxt.osc_en = q_nxt.osc_keep && q_nxt.cur_mode ==
                              sleep_pkg::MODE_STANDBY;
            end
         endcase
         if (q_nxt.st == sleep_pkg::ST_STARTUP) begin
            q_nxt.osc_en = 1'b1;
         end
      end
      if (q_nxt.cfg[sleep_pkg::CFG_DBG_FUSE]) begin
         q_nxt.osc_en = 1'b1;
      end

      // peripheral gates follow their domain, so shutdown only acts
      // while that domain still runs
      q_nxt.per_en = {8{q_nxt.io_en}} & ~q_nxt.power_reduction_register &
                     sleep_pkg::PRR_WMASK;
      q_nxt.per_en[sleep_pkg::PR_ADC] = q_nxt.adc_dom &
         ~q_nxt.power_reduction_register[sleep_pkg::PR_ADC];
      q_nxt.per_en[sleep_pkg::PR_TIM2] =
         q_nxt.cfg[sleep_pkg::CFG_T2_ASYNC] |
         ((q_nxt.io_en | q_nxt.t2s_en) &
          ~q_nxt.power_reduction_register[sleep_pkg::PR_TIM2]);
      q_nxt.acmp_on = q_nxt.cfg[sleep_pkg::CFG_ACMP_EN] & ~deep;
      q_nxt.buf_en = q_nxt.io_en | q_nxt.adc_dom;
      q_nxt.halted = !q_nxt.cpu_en;
      q_nxt.reg_en = ~q_nxt.power_reduction_register & sleep_pkg::PRR_WMASK;
      // reference held up by a comparator on it even while asleep
      q_nxt.vref = q_nxt.cfg[sleep_pkg::CFG_BOD_FUSE] |
                   q_nxt.cfg[sleep_pkg::CFG_ADC_EN] |
                   (q_nxt.cfg[sleep_pkg::CFG_ACMP_EN] &
                    q_nxt.cfg[sleep_pkg::CFG_ACMP_REF]);
   end

   always_ff @(posedge aclk) begin
      q_r <= q_nxt;
   end

   // ==========================================================
   // outputs straight from the state register
   assign s_axi_awready = q_r.awready;
   assign s_axi_wready = q_r.wready;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_arready = q_r.arready;
   assign s_axi_rdata = q_r.rdata;
   assign s_axi_rresp = q_r.rresp;
   assign s_axi_rvalid = q_r.rvalid;
   assign cpu_halted = q_r.halted;
   assign irq_go = q_r.irq_go;
   assign cpu_clk_en = q_r.cpu_en;
   assign flash_clk_en = q_r.flash_en;
   assign io_clk_en = q_r.io_en;
   assign adc_clk_en = q_r.adc_dom;
   assign async_osc_en = q_r.async_en;
   assign main_osc_en = q_r.osc_en;
   assign t2_sync_clk_en = q_r.t2s_en;
   assign periph_clk_en = q_r.per_en;
   assign periph_reg_en = q_r.reg_en;
   assign adc_en = q_r.cfg[sleep_pkg::CFG_ADC_EN];
   assign adc_ext_conv = q_r.adc_ext;
   assign acmp_en = q_r.acmp_on;
   assign vref_en = q_r.vref;
   assign bod_en = q_r.cfg[sleep_pkg::CFG_BOD_FUSE];
   assign wdt_en = q_r.cfg[sleep_pkg::CFG_WDT_EN];
   assign input_buf_en = q_r.buf_en;
   assign din_dis0 = q_r.did0;
   assign din_dis1 = q_r.did1;

endmodule

// *** dv/sleep_ctrl_asserts.sv ***
// Purpose: port-level assertions for the sleep controller
// Assumes: one clock domain, aresetn synchronous and active low
// Notes: bound into every sleep_ctrl instance
`timescale 1ns/10ps
module sleep_ctrl_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic sleep_exec,
   input wire logic cpu_halted,
   input wire logic irq_go,
   input wire logic cpu_clk_en,
   input wire logic io_clk_en,
   input wire logic adc_clk_en,
   input wire logic input_buf_en,
   input wire logic main_osc_en,
   input wire logic t2_sync_clk_en,
   input wire logic adc_en,
   input wire logic acmp_en,
   input wire logic bod_en,
   input wire logic vref_en
);
   // ======================================================
   // properties
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   cpu_gate_a: assert property (cpu_clk_en != cpu_halted)
      else $error("cpu clock gate disagrees with halt state");
   buf_off_a: assert property (
      input_buf_en == (io_clk_en || adc_clk_en))
      else $error("input buffers wrong for stopped clocks");
   vref_need_a: assert property (
      (bod_en || acmp_en || adc_en) |-> vref_en)
      else $error("reference off while a user needs it");
   sync_t2_a: assert property (
      t2_sync_clk_en |-> main_osc_en && !cpu_clk_en && !io_clk_en)
      else $error("timer sync clock shared or without source");
   // explicit fall test: unknown to low after reset is no wake
   wake_halt_a: assert property (
      !cpu_halted && $past(cpu_halted) |-> irq_go &&
      $past(cpu_halted, 2) && $past(cpu_halted, 3) && $past(cpu_halted, 4))
      else $error("resume without four halt cycles");
   go_pulse_a: assert property (irq_go |=> !irq_go)
      else $error("resume strobe longer than one cycle");
   sleep_cause_a: assert property (
      $rose(cpu_halted) |-> $past(sleep_exec))
      else $error("halt entered without a sleep instruction");
   b_block_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");

   cover property (irq_go);
   cover property (t2_sync_clk_en);
   cover property ($rose(cpu_halted) && !adc_clk_en);
endmodule

bind sleep_ctrl sleep_ctrl_asserts chk_u (.*);

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the sleep controller
// Assumes: AXI4-Lite master tasks, fixed-seed lfsr stimulus
// Notes: every bus and sleep task starts on a rising edge
`timescale 1ns/10ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, sleep_exec, ext_wake, int_irq;
   logic adc_irq, t2_ovf, t2_cmp, adc_conv_start, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic cpu_halted, irq_go, cpu_clk_en, flash_clk_en, io_clk_en;
   logic adc_clk_en, async_osc_en, main_osc_en, t2_sync_clk_en, adc_en;
   logic adc_ext_conv, acmp_en, vref_en, bod_en, wdt_en, input_buf_en;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd, g;
   logic [5:0] e;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] periph_clk_en, periph_reg_en, din_dis0, din_dis1;
   int mismatches = 0;
   int n_checks = 0;

   sleep_ctrl dut_u (.*);

   always #5 aclk = ~aclk;

   // ======================================================
   // checking and expectations
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] v);
      n_checks++;
      if (v !== e) begin
         mismatches++;
         $display("wrong value %s exp %h seen %h", nm, e, v);
      end
   endtask

   task automatic chk_n(input string nm, input int e, input int v);
      n_checks++;
      if (v != e) begin
         mismatches++;
         $display("wrong value %s exp %0d seen %0d", nm, e, v);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // {halted, io, adc, buffers, main osc, comparator}
   function automatic logic [5:0] exp_gates(input logic [2:0] m,
                                            input logic dbg);
      logic sl;
      logic lo;
      sl = (m != 3'h4) && (m != 3'h5);
      lo = !sl || (m <= 3'h1);
      return {sl, !sl || m == 3'h0, lo, lo, lo || dbg || m >= 3'h6, lo};
   endfunction

   function automatic int exp_wake(input logic [2:0] m);
      int s;
      s = (m >= 3'h6) ? 6 : int'(sleep_pkg::OSC_STARTUP_CYCLES);
      return 1 + 4 + ((m <= 3'h1) ? 0 : s);
   endfunction

   // ======================================================
   // bus and sleep tasks
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic [2:0] hs;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(negedge aclk);
         hs = {s_axi_awvalid & s_axi_awready,
               s_axi_wvalid & s_axi_wready, s_axi_bvalid};
         r = s_axi_bresp;
         @(posedge aclk);
         if (hs[2]) s_axi_awvalid <= 1'b0;
         if (hs[1]) s_axi_wvalid <= 1'b0;
         if (hs[0]) break;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      logic [1:0] hs;
      logic [33:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(negedge aclk);
         hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
         r = {s_axi_rresp, s_axi_rdata};
         @(posedge aclk);
         if (hs[1]) s_axi_arvalid <= 1'b0;
         if (hs[0]) break;
      end
      s_axi_rready <= 1'b0;
      chk("rdata", ed, r[31:0]);
      chk("rresp", {30'h0, er}, {30'h0, r[33:32]});
   endtask

   task automatic enter(input logic [2:0] m, input logic se);
      axi_wr(sleep_pkg::ADDR_SLEEP_CTRL, {28'h0, m, se}, 2'h0);
      @(posedge aclk);
      sleep_exec <= 1'b1;
      @(posedge aclk);
      sleep_exec <= 1'b0;
      @(negedge aclk);
   endtask

   task automatic wake(input logic [2:0] m, input logic t2);
      int n;
      @(posedge aclk);
      ext_wake <= !t2;
      t2_ovf <= t2;
      n = 0;
      do begin
         @(posedge aclk);
         ext_wake <= 1'b0;
         t2_ovf <= 1'b0;
         n++;
         @(negedge aclk);
      end while (irq_go !== 1'b1 && n < 40);
      chk_n("wake cycles", exp_wake(m), n);
      axi_wr(sleep_pkg::ADDR_SLEEP_CTRL, 32'h0, 2'h0);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ======================================================
   // main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, sleep_exec, ext_wake} = '0;
      {int_irq, adc_irq, t2_ovf, t2_cmp, adc_conv_start} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      rnd = 32'h478FA7DF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(sleep_pkg::ADDR_SLEEP_CTRL, 32'h0, 2'h0);
      repeat (6) begin
         rnd = lfsr(rnd);
         axi_wr(sleep_pkg::ADDR_SLEEP_CTRL, rnd, 2'h0);
         axi_rd(sleep_pkg::ADDR_SLEEP_CTRL, {28'h0, rnd[3:0]}, 2'h0);
      end
      axi_wr(sleep_pkg::ADDR_PWR_RED, 32'hFF, 2'h0);
      axi_rd(sleep_pkg::ADDR_PWR_RED, 32'hEF, 2'h0);
      chk("reg access", 32'h0, {24'h0, periph_reg_en});
      axi_wr(sleep_pkg::ADDR_PWR_RED, 32'h0, 2'h0);
      @(negedge aclk);
      chk("reg access", 32'hEF, {24'h0, periph_reg_en});
      rnd = lfsr(rnd);
      axi_wr(sleep_pkg::ADDR_DIN_DIS0, {24'h0, rnd[7:0]}, 2'h0);
      axi_wr(sleep_pkg::ADDR_DIN_DIS1, {24'h0, rnd[15:8]}, 2'h0);
      @(negedge aclk);
      chk("pin disables", {16'h0, rnd[15:0]}, {16'h0, din_dis1, din_dis0});
      axi_wr(12'hFFC, rnd, 2'h2);
      axi_rd(12'hFFC, 32'h0, 2'h2);
      enter(3'h2, 1'b0);
      chk("halted", 32'h0, {31'h0, cpu_halted});
      for (int p = 0; p < 2; p++) begin
         axi_wr(sleep_pkg::ADDR_CONFIG, 32'h0DC | (p << 8), 2'h0);
         for (int m = 0; m < 8; m++) begin
            enter(3'(m), 1'b1);
            g = {26'h0, cpu_halted, io_clk_en, adc_clk_en, input_buf_en,
                 main_osc_en, acmp_en};
            e = exp_gates(3'(m), p[0]);
            chk("gates", {26'h0, e}, g);
            chk("kept on", 32'hF, {28'h0, vref_en, adc_en, bod_en, wdt_en});
            chk("periph clocks",
                {23'h0, !e[5], e[4] ? 8'hEF : {7'h0, e[3]}},
                {23'h0, flash_clk_en, periph_clk_en});
            if (m != 4 && m != 5) wake(3'(m), 1'b0);
         end
      end
      axi_wr(sleep_pkg::ADDR_CONFIG, 32'hA01, 2'h0);
      enter(3'h3, 1'b1);
      g = {28'h0, t2_sync_clk_en, async_osc_en, main_osc_en, io_clk_en};
      chk("timer clocks", 32'hA, g);
      axi_rd(sleep_pkg::ADDR_STATUS, 32'h2D, 2'h0);
      chk("ext conv", 32'h1, {31'h0, adc_ext_conv});
      wake(3'h3, 1'b1);
      axi_wr(sleep_pkg::ADDR_CONFIG, 32'h201, 2'h0);
      enter(3'h3, 1'b1);
      wait_masked();
      wake(3'h3, 1'b0);
      @(posedge aclk);
      adc_conv_start <= 1'b1;
      @(posedge aclk);
      adc_conv_start <= 1'b0;
      @(negedge aclk);
      chk("ext conv", 32'h0, {31'h0, adc_ext_conv});
      end_of_test();
   end

   task automatic wait_masked;
      @(posedge aclk);
      t2_ovf <= 1'b1;
      @(posedge aclk);
      t2_ovf <= 1'b0;
      repeat (30) @(posedge aclk);
      @(negedge aclk);
      chk("masked wake", 32'h1, {31'h0, cpu_halted});
   endtask

   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
endmodule
